// ===== hw/usart_cfg_pkg.sv
// Shared constants for the serial baud and infrared configuration block
`default_nettype none
package usart_cfg_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_BAUD_LOW = 6'h08;
    localparam logic [5:0] IDX_BAUD_HIGH = 6'h09;
    localparam logic [5:0] IDX_AUTOBAUD_WINDOW = 6'h0a;
    localparam logic [5:0] IDX_DEBUG_RUN = 6'h0b;
    localparam logic [5:0] IDX_INFRARED_EVENT = 6'h0c;
    localparam logic [5:0] IDX_TX_PULSE = 6'h0d;
    localparam logic [5:0] IDX_RX_FILTER = 6'h0e;
    localparam logic [5:0] IDX_MODE_CTRL = 6'h0f;
    localparam logic [5:0] IDX_AUTOBAUD_STATUS = 6'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int WINDOW_LSB = 6;
    localparam int MODE_COMM_LSB = 0;
    localparam int MODE_RX_LSB = 2;
    localparam int MODE_TX_ON_BIT = 4;
    localparam int MODE_RX_ON_BIT = 5;
    localparam int STATUS_REJECT_BIT = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RESET_DIVISOR = 16'h0000;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Mode encodings and coding constants
    // ------------------------------------------------------------
    localparam logic [1:0] COMM_INFRARED = 2'h2;
    localparam logic [1:0] RX_CONSTRAINED_AUTOBAUD = 2'h3;
    localparam logic [7:0] TX_PULSE_THREE_SIXTEENTHS = 8'h00;
    localparam logic [7:0] TX_PULSE_BYPASS = 8'hff;
    localparam logic [7:0] THREE_SIXTEENTHS_SAMPLES = 8'h03;
    localparam logic [3:0] LAST_SAMPLE_PHASE = 4'hf;
    localparam logic [7:0] PAIR_NOMINAL_SAMPLES = 8'h20;
    localparam logic [4:0] RX_STRETCH_SAMPLES = 5'h10;

    typedef enum logic [1:0] {
        window_plus_minus_six = 2'h0,
        window_plus_minus_five = 2'h1,
        window_plus_minus_seven = 2'h2,
        window_plus_minus_eight = 2'h3
    } autobaud_window_size_t;

    // Tolerance in samples for each window code
    function automatic logic [7:0] window_tolerance(input logic [1:0] code);
        case (code)
            window_plus_minus_six: window_tolerance = 8'h06;
            window_plus_minus_five: window_tolerance = 8'h05;
            window_plus_minus_seven: window_tolerance = 8'h07;
            default: window_tolerance = 8'h08;
        endcase
    endfunction
endpackage
`default_nettype wire

// ===== hw/pulse_run_filter.sv
// Consecutive-sample filter that accepts a received infrared pulse
`default_nettype none
module pulse_run_filter #(
    parameter int WIDTH = 7
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Sample stream
    input wire logic level,
    input wire logic [WIDTH-1:0] threshold,
    // Result
    output logic accept
);
    logic [WIDTH-1:0] run_count;
    logic armed;

    // Count consecutive high samples, one accept per pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_count <= '0;
            armed <= 1'b1;
            accept <= 1'b0;
        end else if (!level) begin
            run_count <= '0;
            armed <= 1'b1;
            accept <= 1'b0;
        end else begin
            accept <= armed && (run_count == threshold);
            if (run_count == threshold) begin
                armed <= 1'b0;
            end else begin
                run_count <= run_count + 1'b1;
            end
        end
    end

    AST_FILTER_NEEDS_RUN: assert property (@(posedge pclk) disable iff (!presetn)
        accept && threshold == 7'h02 |-> $past(level, 1) && $past(level, 2) && $past(level, 3))
        else $error("pulse accepted before three consecutive samples");
endmodule // pulse_run_filter
`default_nettype wire

// ===== hw/usart_baud_infrared_config.sv
// Baud prescaler, auto-baud window, debug run and infrared coding with APB registers
`default_nettype none
module usart_baud_infrared_config (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System side
    input wire logic cpu_debug_halt,
    input wire logic infrared_event_in,
    input wire logic tx_data_in,
    output logic rx_data_out,
    output logic sample_tick,
    output logic autobaud_update,
    // Line side
    input wire logic rxd_pin,
    output logic txd_out
);
    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [15:0] divisor;
    logic [1:0] autobaud_window_size;
    logic run_during_debug_halt;
    logic infrared_event_input_on;
    logic [7:0] tx_pulse_length;
    logic [6:0] rx_pulse_filter_count;
    logic [1:0] comm_mode_select;
    logic [1:0] receiver_mode_select;
    logic transmitter_on;
    logic receiver_on;
    logic autobaud_reject;
    logic [7:0] last_pair_count;
    logic [15:0] presc;
    logic [3:0] phase;
    logic [7:0] tx_pulse_cnt;
    logic rx_sync1, rx_sync2;
    logic rx_prev;
    logic [4:0] rx_stretch;
    logic [7:0] pair_count;
    logic pair_armed;

    // ------------------------------------------------------------
    // Decode and mode terms
    // ------------------------------------------------------------
    logic [5:0] idx;
    logic access, wr_access, divisor_write, running, bit_start;
    logic infrared_comm_mode, constrained_autobaud_mode, tx_bypass, tx_coded;
    logic rx_src, filter_accept, pair_edge, in_window, hw_update, sw_clear_reject;
    logic [7:0] tol;
    logic [23:0] scaled;
    logic [15:0] next_divisor;

    assign idx = paddr[7:2];
    assign access = psel && penable && pready;
    assign wr_access = access && pwrite;
    assign divisor_write = wr_access && (idx == usart_cfg_pkg::IDX_BAUD_LOW
        || idx == usart_cfg_pkg::IDX_BAUD_HIGH);
    assign running = !cpu_debug_halt || run_during_debug_halt;
    assign bit_start = running && sample_tick && phase == usart_cfg_pkg::LAST_SAMPLE_PHASE;
    assign infrared_comm_mode = comm_mode_select == usart_cfg_pkg::COMM_INFRARED;
    assign constrained_autobaud_mode = receiver_on
        && receiver_mode_select == usart_cfg_pkg::RX_CONSTRAINED_AUTOBAUD;
    assign tx_bypass = tx_pulse_length == usart_cfg_pkg::TX_PULSE_BYPASS;
    assign tx_coded = infrared_comm_mode && !tx_bypass;
    assign sw_clear_reject = wr_access && idx == usart_cfg_pkg::IDX_AUTOBAUD_STATUS
        && pwdata[usart_cfg_pkg::STATUS_REJECT_BIT];

    // Receive source: event channel only when enabled and running (not halted, or debug run set)
    assign rx_src = (infrared_comm_mode && tx_bypass && infrared_event_input_on && running)
        ? infrared_event_in : rx_sync2;

    // Auto-baud window and divisor scaling
    assign tol = usart_cfg_pkg::window_tolerance(autobaud_window_size);
    assign in_window = pair_count >= usart_cfg_pkg::PAIR_NOMINAL_SAMPLES - tol
        && pair_count <= usart_cfg_pkg::PAIR_NOMINAL_SAMPLES + tol;
    assign pair_edge = constrained_autobaud_mode && running && rx_prev && !rx_data_out;
    assign hw_update = pair_edge && pair_armed && in_window;
    assign scaled = {8'h00, divisor} * {16'h0000, pair_count};
    assign next_divisor = scaled[20:5];

    // ------------------------------------------------------------
    // APB register writes
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            autobaud_window_size <= 2'h0;
            run_during_debug_halt <= 1'b0;
            infrared_event_input_on <= 1'b0;
            tx_pulse_length <= usart_cfg_pkg::RESET_BYTE;
            rx_pulse_filter_count <= 7'h00;
            comm_mode_select <= 2'h0;
            receiver_mode_select <= 2'h0;
            transmitter_on <= 1'b0;
            receiver_on <= 1'b0;
        end else if (wr_access) begin
            case (idx)
                usart_cfg_pkg::IDX_AUTOBAUD_WINDOW: autobaud_window_size <=
                    pwdata[usart_cfg_pkg::WINDOW_LSB +: 2];
                usart_cfg_pkg::IDX_DEBUG_RUN: run_during_debug_halt <= pwdata[0];
                usart_cfg_pkg::IDX_INFRARED_EVENT: infrared_event_input_on <= pwdata[0];
                usart_cfg_pkg::IDX_TX_PULSE: tx_pulse_length <= pwdata[7:0];
                usart_cfg_pkg::IDX_RX_FILTER: rx_pulse_filter_count <= pwdata[6:0];
                usart_cfg_pkg::IDX_MODE_CTRL: begin
                    comm_mode_select <= pwdata[usart_cfg_pkg::MODE_COMM_LSB +: 2];
                    receiver_mode_select <= pwdata[usart_cfg_pkg::MODE_RX_LSB +: 2];
                    transmitter_on <= pwdata[usart_cfg_pkg::MODE_TX_ON_BIT];
                    receiver_on <= pwdata[usart_cfg_pkg::MODE_RX_ON_BIT];
                end
                default: ;
            endcase
        end
    end

    // Divisor: software byte writes win over auto-baud update
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divisor <= usart_cfg_pkg::RESET_DIVISOR;
        end else if (divisor_write) begin
            if (idx == usart_cfg_pkg::IDX_BAUD_LOW) begin
                divisor[7:0] <= pwdata[7:0];
            end else begin
                divisor[15:8] <= pwdata[7:0];
            end
        end else if (hw_update) begin
            divisor <= next_divisor;
        end
    end

    // APB answer prepared in the setup cycle, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (idx < usart_cfg_pkg::IDX_BAUD_LOW
                || idx > usart_cfg_pkg::IDX_AUTOBAUD_STATUS);
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (idx)
                    usart_cfg_pkg::IDX_BAUD_LOW: prdata[7:0] <= divisor[7:0];
                    usart_cfg_pkg::IDX_BAUD_HIGH: prdata[7:0] <= divisor[15:8];
                    usart_cfg_pkg::IDX_AUTOBAUD_WINDOW:
                        prdata[usart_cfg_pkg::WINDOW_LSB +: 2] <= autobaud_window_size;
                    usart_cfg_pkg::IDX_DEBUG_RUN: prdata[0] <= run_during_debug_halt;
                    usart_cfg_pkg::IDX_INFRARED_EVENT: prdata[0] <= infrared_event_input_on;
                    usart_cfg_pkg::IDX_TX_PULSE: prdata[7:0] <= tx_pulse_length;
                    usart_cfg_pkg::IDX_RX_FILTER: prdata[6:0] <= rx_pulse_filter_count;
                    usart_cfg_pkg::IDX_MODE_CTRL: prdata[5:0] <= {receiver_on, transmitter_on,
                        receiver_mode_select, comm_mode_select};
                    usart_cfg_pkg::IDX_AUTOBAUD_STATUS: prdata[8:0] <=
                        {autobaud_reject, last_pair_count};
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Baud prescaler and sample phase
    // ------------------------------------------------------------
    // Divisor writes reload at once; frames in flight are software's concern
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc <= usart_cfg_pkg::RESET_DIVISOR;
            sample_tick <= 1'b0;
        end else if (divisor_write) begin
            presc <= (idx == usart_cfg_pkg::IDX_BAUD_LOW) ? {divisor[15:8], pwdata[7:0]}
                : {pwdata[7:0], divisor[7:0]};
            sample_tick <= 1'b0;
        end else if (hw_update) begin
            presc <= next_divisor;
            sample_tick <= 1'b0;
        end else if (running) begin
            sample_tick <= presc == 16'h0000;
            presc <= (presc == 16'h0000) ? divisor : presc - 16'h0001;
        end else begin
            sample_tick <= 1'b0;
        end
    end

    // Sixteen samples make one bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 4'h0;
        end else if (running && sample_tick) begin
            phase <= phase + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Infrared transmit coding
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_out <= 1'b1;
            tx_pulse_cnt <= 8'h00;
        end else if (!tx_coded) begin
            txd_out <= tx_data_in;
            tx_pulse_cnt <= 8'h00;
        end else if (bit_start && transmitter_on && !tx_data_in) begin
            txd_out <= 1'b1;
            if (tx_pulse_length == usart_cfg_pkg::TX_PULSE_THREE_SIXTEENTHS) begin
                tx_pulse_cnt <= usart_cfg_pkg::THREE_SIXTEENTHS_SAMPLES - 8'h01;
            end else begin
                tx_pulse_cnt <= tx_pulse_length - 8'h01;
            end
        end else if (tx_pulse_length == usart_cfg_pkg::TX_PULSE_THREE_SIXTEENTHS) begin
            if (running && sample_tick) begin
                if (tx_pulse_cnt == 8'h00) begin
                    txd_out <= 1'b0;
                end else begin
                    tx_pulse_cnt <= tx_pulse_cnt - 8'h01;
                end
            end
        end else if (tx_pulse_cnt == 8'h00) begin
            txd_out <= 1'b0;
        end else begin
            tx_pulse_cnt <= tx_pulse_cnt - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Receive path: synchroniser, filter, decode
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sync1 <= 1'b1;
            rx_sync2 <= 1'b1;
        end else begin
            rx_sync1 <= rxd_pin;
            rx_sync2 <= rx_sync1;
        end
    end

    pulse_run_filter #(.WIDTH(7)) rx_filter (
        .pclk(pclk),
        .presetn(presetn),
        .level(rx_src && tx_coded),
        .threshold(rx_pulse_filter_count),
        .accept(filter_accept)
    );

    // Accepted pulse shows as a low bit for sixteen samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_out <= 1'b1;
            rx_stretch <= 5'h00;
            rx_prev <= 1'b1;
        end else begin
            rx_prev <= rx_data_out;
            if (!tx_coded) begin
                rx_data_out <= rx_src;
                rx_stretch <= 5'h00;
            end else if (filter_accept && receiver_on) begin
                rx_data_out <= 1'b0;
                rx_stretch <= usart_cfg_pkg::RX_STRETCH_SAMPLES;
            end else if (rx_stretch == 5'h00) begin
                rx_data_out <= 1'b1;
            end else if (running && sample_tick) begin
                rx_stretch <= rx_stretch - 5'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Constrained auto-baud measurement
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_count <= 8'h00;
            pair_armed <= 1'b0;
            last_pair_count <= 8'h00;
            autobaud_update <= 1'b0;
        end else begin
            autobaud_update <= hw_update;
            if (!constrained_autobaud_mode) begin
                pair_count <= 8'h00;
                pair_armed <= 1'b0;
            end else if (pair_edge) begin
                pair_count <= 8'h00;
                pair_armed <= 1'b1;
                if (pair_armed) begin
                    last_pair_count <= pair_count;
                end
            end else if (running && sample_tick && pair_count != 8'hff) begin
                pair_count <= pair_count + 8'h01;
            end
        end
    end

    // Sticky reject flag, a new reject wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            autobaud_reject <= 1'b0;
        end else if (pair_edge && pair_armed && !in_window) begin
            autobaud_reject <= 1'b1;
        end else if (sw_clear_reject) begin
            autobaud_reject <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_BAUD_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
        divisor_write && idx == usart_cfg_pkg::IDX_BAUD_LOW
        |=> presc == {$past(divisor[15:8]), $past(pwdata[7:0])})
        else $error("prescaler not reloaded by divisor write");
    AST_BAUD_HIGH_READ: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && idx == usart_cfg_pkg::IDX_BAUD_HIGH
        |=> prdata == {24'h00_0000, $past(divisor[15:8])})
        else $error("high divisor byte read wrong");
    AST_WINDOW_REJECT: assert property (@(posedge pclk) disable iff (!presetn)
        pair_edge && pair_armed && !in_window && !divisor_write
        |=> autobaud_reject && !autobaud_update && $stable(divisor))
        else $error("out-of-window pair changed divisor");
    AST_WINDOW_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
        pair_edge && pair_armed && pair_count == 8'h28 && autobaud_window_size == 2'h3
        |=> autobaud_update)
        else $error("pair of 40 samples refused in widest window");
    AST_DEBUG_HALT: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_debug_halt && !run_during_debug_halt && !divisor_write
        |=> $stable(presc) && !sample_tick)
        else $error("prescaler ran during debug halt");
    AST_EVENT_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
        !infrared_event_input_on && !tx_coded |=> rx_data_out == $past(rx_sync2))
        else $error("event input used while disabled");
    AST_TX_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        !tx_coded |=> txd_out == $past(tx_data_in))
        else $error("transmit not passed through");
    AST_TX_FIXED_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        tx_coded && bit_start && transmitter_on && !tx_data_in && tx_pulse_length == 8'h03
        |=> txd_out [*3] ##1 !txd_out)
        else $error("fixed pulse not three clocks long");
endmodule // usart_baud_infrared_config
`default_nettype wire

// ===== sim/line_partner.sv
// Remote transceiver model: measures coded pulses, drives the receive line
`default_nettype none
module line_partner (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Line
    input wire logic txd_out,
    output logic rxd_pin,
    // Test control and result
    input wire logic send_space,
    output logic [15:0] pulse_cycles
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] run;
    // Line idles high; a space is driven only on request
    assign rxd_pin = ~send_space;
    // Width of the last high pulse, in clock cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 16'h0000;
            pulse_cycles <= 16'h0000;
        end else if (txd_out) begin
            run <= run + 16'h0001;
        end else begin
            if (run != 16'h0000) pulse_cycles <= run;
            run <= 16'h0000;
        end
    end
endmodule // line_partner
`default_nettype wire

// ===== sim/usart_baud_infrared_config_tb.sv
// Self-checking bench for the baud and infrared configuration block
`default_nettype none
module usart_baud_infrared_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, halt, ev_in, tx_in, rx_out;
    logic tick, ab_upd, rxd, txd, space, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] pulse;
    int fail_count = 0;
    int checks_done = 0;
    int n;
    logic [5:0] idx_tab [7] = '{6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e};
    logic [31:0] mask_tab [7] = '{32'h0000_00ff, 32'h0000_00ff, 32'h0000_00c0,
        32'h0000_0001, 32'h0000_0001, 32'h0000_00ff, 32'h0000_007f};
    logic [7:0] len_tab [3] = '{8'h01, 8'h03, 8'h00};
    logic [31:0] wid_tab [3] = '{32'h0000_0001, 32'h0000_0003, 32'h0000_000c};
    int upd_seen = 0;
    usart_baud_infrared_config dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_debug_halt(halt), .infrared_event_in(ev_in),
        .tx_data_in(tx_in), .rx_data_out(rx_out), .sample_tick(tick), .autobaud_update(ab_upd),
        .rxd_pin(rxd), .txd_out(txd));
    line_partner partner_u (.pclk(pclk), .presetn(presetn), .txd_out(txd), .rxd_pin(rxd),
        .send_space(space), .pulse_cycles(pulse));
    // Auto-baud update pulses seen
    always @(posedge pclk) begin
        if (ab_upd === 1'b1) upd_seen <= upd_seen + 1;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        int w;
        w = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            w++;
            if (w > 50) begin
                fail_count++;
                end_sim();
            end
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Sample ticks seen over a number of cycles
    task automatic count_ticks(input int cycles);
        n = 0;
        repeat (cycles) begin
            @(negedge pclk);
            if (tick === 1'b1) n++;
        end
        @(posedge pclk);
    endtask
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, halt, ev_in, space} = 7'b0;
        tx_in = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, idx_tab[i], 32'h0000_0000);
            check(rd, 32'h0000_0000);
            apb(1'b1, idx_tab[i], 32'hffff_ffff);
            apb(1'b0, idx_tab[i], 32'h0000_0000);
            check(rd, mask_tab[i]);
        end
        apb(1'b0, 6'h04, 32'h0000_0000);
        check({31'h0000_0000, err}, 32'h0000_0001);
        check(rd, 32'h0000_0000);
        $display("registers done");
        apb(1'b1, 6'h0f, 32'h0000_0000);
        apb(1'b1, 6'h08, 32'h0000_0003);
        apb(1'b1, 6'h09, 32'h0000_0000);
        apb(1'b1, 6'h0b, 32'h0000_0000);
        count_ticks(40);
        check(n, 32'h0000_000a);
        halt <= 1'b1;
        @(posedge pclk);
        count_ticks(40);
        check(n, 32'h0000_0000);
        apb(1'b1, 6'h0b, 32'h0000_0001);
        count_ticks(40);
        check(n, 32'h0000_000a);
        halt <= 1'b0;
        $display("prescaler done");
        tx_in <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 6'h0f, 32'h0000_0000);
            apb(1'b1, 6'h0d, {24'h00_0000, len_tab[i]});
            apb(1'b1, 6'h0f, 32'h0000_0012);
            repeat (300) @(posedge pclk);
            check({16'h0000, pulse}, wid_tab[i]);
        end
        $display("pulse coding done");
        apb(1'b1, 6'h0f, 32'h0000_0000);
        apb(1'b1, 6'h0d, 32'h0000_00ff);
        apb(1'b1, 6'h0c, 32'h0000_0001);
        apb(1'b1, 6'h0f, 32'h0000_0032);
        repeat (4) @(posedge pclk);
        check({31'h0000_0000, rx_out}, 32'h0000_0000);
        check({31'h0000_0000, txd}, 32'h0000_0000);
        tx_in <= 1'b1;
        apb(1'b1, 6'h0c, 32'h0000_0000);
        repeat (4) @(posedge pclk);
        check({31'h0000_0000, txd}, 32'h0000_0001);
        check({31'h0000_0000, rx_out}, 32'h0000_0001);
        space <= 1'b1;
        repeat (6) @(posedge pclk);
        check({31'h0000_0000, rx_out}, 32'h0000_0000);
        $display("bypass done");
        space <= 1'b0;
        apb(1'b1, 6'h08, 32'h0000_0000);
        apb(1'b1, 6'h0f, 32'h0000_002c);
        for (int g = 0; g < 3; g++) begin
            space <= 1'b1;
            repeat (5) @(posedge pclk);
            space <= 1'b0;
            repeat (36 + 2 * g) @(posedge pclk);
        end
        check(upd_seen, 32'h0000_0001);
        apb(1'b0, 6'h10, 32'h0000_0000);
        check(rd, 32'h0000_0129);
        apb(1'b1, 6'h10, 32'h0000_0100);
        apb(1'b0, 6'h10, 32'h0000_0000);
        check(rd, 32'h0000_0029);
        $display("autobaud done");
        end_sim();
    end
endmodule // usart_baud_infrared_config_tb
`default_nettype wire
